// ### core/ccr_regs.sv
// Calibration and setup register bank for a two-channel converter.
// Assumes a classic Wishbone master on clk_i, 32-bit data, byte addresses.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Chan0 gain upper RW, reset 8000h
// - Chan0 gain lower: high byte RW, low zero
// - Phase delay bits 15:6, signed, reset zero
// - Bit 2 disables channel DC block
// - Bits 1:0 choose input, four codes
// - Chan1 offset upper RW, reset zero
// - Chan1 offset lower: high byte RW, low zero
// - Chan1 gain upper RW, reset 8000h
// - Chan1 gain lower: high byte RW, low zero
// - Chan0 setup shares chan1 layout
// - Global 4-bit coefficient, zero disables filter
module ccr_regs (
    input  wire logic        clk_i,                // 20 MHz system clock
    input  wire logic        rst_i,                // Synchronous reset, high
    input  wire logic        wb_cyc_i,             // Bus cycle
    input  wire logic        wb_stb_i,             // Strobe
    input  wire logic        wb_we_i,              // Write enable
    input  wire logic [7:0]  wb_adr_i,             // Byte address
    input  wire logic [3:0]  wb_sel_i,             // Byte lanes
    input  wire logic [31:0] wb_dat_i,             // Write data
    output logic      [31:0] wb_dat_o,             // Read data
    output logic             wb_ack_o,             // Acknowledge
    output logic      [23:0] chan0_gain_o,         // Channel 0 gain word
    output logic      [23:0] chan1_gain_o,         // Channel 1 gain word
    output logic      [23:0] chan1_offset_o,       // Channel 1 offset word
    output logic      [9:0]  chan0_phase_delay_o,  // Channel 0 phase, signed
    output logic      [9:0]  chan1_phase_delay_o,  // Channel 1 phase, signed
    output logic             chan0_hpf_en_o,       // Channel 0 filter active
    output logic             chan1_hpf_en_o,       // Channel 1 filter active
    output logic      [3:0]  global_hpf_coeff_o,   // Global coefficient code
    output logic      [1:0]  chan0_input_select_o, // Channel 0 input code
    output logic      [1:0]  chan1_input_select_o  // Channel 1 input code
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [15:0] chan0_setup_reg;      // Channel 0 setup
    logic [15:0] chan0_gain_hi_reg;    // Channel 0 gain bits 23:8
    logic [15:0] chan0_gain_lo_reg;    // Channel 0 gain bits 7:0 in 15:8
    logic [15:0] chan1_setup_reg;      // Channel 1 setup
    logic [15:0] chan1_offset_hi_reg;  // Channel 1 offset bits 23:8
    logic [15:0] chan1_offset_lo_reg;  // Channel 1 offset bits 7:0 in 15:8
    logic [15:0] chan1_gain_hi_reg;    // Channel 1 gain bits 23:8
    logic [15:0] chan1_gain_lo_reg;    // Channel 1 gain bits 7:0 in 15:8
    logic [3:0]  global_hpf_coeff_reg; // Global filter coefficient code
    logic        wb_ack_reg;           // Acknowledge flop
    logic [31:0] wb_dat_reg;           // Read data flop

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic       req;      // New request, not yet acknowledged
    logic       wr;       // Write taken this cycle
    logic [5:0] idx;      // Word index
    logic       adr_ok;   // Low address bits zero, word-aligned

    // Acking one cycle after the request, then dropping, keeps each access two cycles
    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    // Writes land on the acknowledge edge only
    assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_reg;
    assign idx    = wb_adr_i[7:2];
    assign adr_ok = (wb_adr_i[1:0] == 2'h0);

    // Merge write data into a register under byte lanes and a writable mask
    function automatic logic [15:0] merge(input logic [15:0] old_val,
                                          input logic [15:0] mask);
        logic [15:0] lane;
        lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & mask;
        merge = (old_val & ~lane) | (wb_dat_i[15:0] & lane);
    endfunction

    // True when this cycle writes the register at the given index
    function automatic logic hit(input logic [5:0] target);
        hit = wr & adr_ok & (idx == target);
    endfunction

    // ****************************************************************
    // Acknowledge
    // ****************************************************************
    // Every request, mapped or not, is acknowledged; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= req;
        end
    end

    // ****************************************************************
    // Gain registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan0_gain_hi_reg <= ccr_pkg::CCR_RST_GAIN_HI;
            chan0_gain_lo_reg <= ccr_pkg::CCR_RST_ZERO;
            chan1_gain_hi_reg <= ccr_pkg::CCR_RST_GAIN_HI;
            chan1_gain_lo_reg <= ccr_pkg::CCR_RST_ZERO;
        end else begin
            if (hit(ccr_pkg::CCR_IDX_CH0_GAIN_HI)) begin
                chan0_gain_hi_reg <= merge(chan0_gain_hi_reg, 16'hffff);
            end
            if (hit(ccr_pkg::CCR_IDX_CH0_GAIN_LO)) begin
                chan0_gain_lo_reg <= merge(chan0_gain_lo_reg, ccr_pkg::CCR_MASK_LO);
            end
            if (hit(ccr_pkg::CCR_IDX_CH1_GAIN_HI)) begin
                chan1_gain_hi_reg <= merge(chan1_gain_hi_reg, 16'hffff);
            end
            if (hit(ccr_pkg::CCR_IDX_CH1_GAIN_LO)) begin
                chan1_gain_lo_reg <= merge(chan1_gain_lo_reg, ccr_pkg::CCR_MASK_LO);
            end
        end
    end

    // ****************************************************************
    // Offset registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan1_offset_hi_reg <= ccr_pkg::CCR_RST_ZERO;
            chan1_offset_lo_reg <= ccr_pkg::CCR_RST_ZERO;
        end else begin
            if (hit(ccr_pkg::CCR_IDX_CH1_OFS_HI)) begin
                chan1_offset_hi_reg <= merge(chan1_offset_hi_reg, 16'hffff);
            end
            if (hit(ccr_pkg::CCR_IDX_CH1_OFS_LO)) begin
                chan1_offset_lo_reg <= merge(chan1_offset_lo_reg, ccr_pkg::CCR_MASK_LO);
            end
        end
    end

    // ****************************************************************
    // Setup registers and global coefficient
    // ****************************************************************
    // Reserved bits 5:3 are masked so they always read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chan0_setup_reg      <= ccr_pkg::CCR_RST_ZERO;
            chan1_setup_reg      <= ccr_pkg::CCR_RST_ZERO;
            global_hpf_coeff_reg <= ccr_pkg::CCR_COEF_OFF;
        end else begin
            if (hit(ccr_pkg::CCR_IDX_CH0_SETUP)) begin
                chan0_setup_reg <= merge(chan0_setup_reg, ccr_pkg::CCR_MASK_SETUP);
            end
            if (hit(ccr_pkg::CCR_IDX_CH1_SETUP)) begin
                chan1_setup_reg <= merge(chan1_setup_reg, ccr_pkg::CCR_MASK_SETUP);
            end
            if (hit(ccr_pkg::CCR_IDX_HPF_CTRL) && wb_sel_i[0]) begin
                global_hpf_coeff_reg <= wb_dat_i[ccr_pkg::CCR_COEF_MSB:0];
            end
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Registered so the data is valid in the same cycle as the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_reg <= 32'h0000_0000;
            if (adr_ok) begin
                case (idx)
                    ccr_pkg::CCR_IDX_CH0_SETUP:   wb_dat_reg[15:0] <= chan0_setup_reg;
                    ccr_pkg::CCR_IDX_CH0_GAIN_HI: wb_dat_reg[15:0] <= chan0_gain_hi_reg;
                    ccr_pkg::CCR_IDX_CH0_GAIN_LO: wb_dat_reg[15:0] <= chan0_gain_lo_reg;
                    ccr_pkg::CCR_IDX_CH1_SETUP:   wb_dat_reg[15:0] <= chan1_setup_reg;
                    ccr_pkg::CCR_IDX_CH1_OFS_HI:  wb_dat_reg[15:0] <= chan1_offset_hi_reg;
                    ccr_pkg::CCR_IDX_CH1_OFS_LO:  wb_dat_reg[15:0] <= chan1_offset_lo_reg;
                    ccr_pkg::CCR_IDX_CH1_GAIN_HI: wb_dat_reg[15:0] <= chan1_gain_hi_reg;
                    ccr_pkg::CCR_IDX_CH1_GAIN_LO: wb_dat_reg[15:0] <= chan1_gain_lo_reg;
                    ccr_pkg::CCR_IDX_HPF_CTRL:    wb_dat_reg[3:0]  <= global_hpf_coeff_reg;
                    default:                      wb_dat_reg       <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;

    // ****************************************************************
    // Datapath view
    // ****************************************************************
    // Calibration words join the upper register with the lower high byte
    assign chan0_gain_o   = {chan0_gain_hi_reg,
                             chan0_gain_lo_reg[ccr_pkg::CCR_LOBYTE_MSB:ccr_pkg::CCR_LOBYTE_LSB]};
    assign chan1_gain_o   = {chan1_gain_hi_reg,
                             chan1_gain_lo_reg[ccr_pkg::CCR_LOBYTE_MSB:ccr_pkg::CCR_LOBYTE_LSB]};
    assign chan1_offset_o = {chan1_offset_hi_reg,
                             chan1_offset_lo_reg[ccr_pkg::CCR_LOBYTE_MSB:ccr_pkg::CCR_LOBYTE_LSB]};

    assign chan0_phase_delay_o  = chan0_setup_reg[ccr_pkg::CCR_PHASE_MSB:ccr_pkg::CCR_PHASE_LSB];
    assign chan1_phase_delay_o  = chan1_setup_reg[ccr_pkg::CCR_PHASE_MSB:ccr_pkg::CCR_PHASE_LSB];
    assign chan0_input_select_o = chan0_setup_reg[ccr_pkg::CCR_SEL_MSB:0];
    assign chan1_input_select_o = chan1_setup_reg[ccr_pkg::CCR_SEL_MSB:0];
    assign global_hpf_coeff_o   = global_hpf_coeff_reg;

    // Filter runs only when the global code is nonzero and the channel has not opted out
    assign chan0_hpf_en_o = (global_hpf_coeff_reg != ccr_pkg::CCR_COEF_OFF)
                            & ~chan0_setup_reg[ccr_pkg::CCR_HPF_OFF];
    assign chan1_hpf_en_o = (global_hpf_coeff_reg != ccr_pkg::CCR_COEF_OFF)
                            & ~chan1_setup_reg[ccr_pkg::CCR_HPF_OFF];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_wr_full(logic [5:0] target);
        wr && adr_ok && idx == target && wb_sel_i == 4'hf;
    endsequence

    property p_ch0_gain_hi_rst;
        @(posedge clk_i) $fell(rst_i) |-> chan0_gain_hi_reg == 16'h8000;
    endproperty
    a_ch0_gain_hi_rst: assert property (p_ch0_gain_hi_rst) else $error("ch0 gain hi reset");

    property p_ch0_gain_lo_low;
        @(posedge clk_i) disable iff (rst_i) chan0_gain_lo_reg[7:0] == 8'h00;
    endproperty
    a_ch0_gain_lo_low: assert property (p_ch0_gain_lo_low) else $error("ch0 gain lo byte");

    property p_ch1_phase_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_SETUP) |=> chan1_phase_delay_o == $past(wb_dat_i[15:6]);
    endproperty
    a_ch1_phase_wr: assert property (p_ch1_phase_wr) else $error("ch1 phase write");

    property p_ch1_hpf;
        @(posedge clk_i) disable iff (rst_i) chan1_setup_reg[2] |-> !chan1_hpf_en_o;
    endproperty
    a_ch1_hpf: assert property (p_ch1_hpf) else $error("ch1 filter off");

    property p_ch1_sel_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_SETUP) |=> chan1_input_select_o == $past(wb_dat_i[1:0]);
    endproperty
    a_ch1_sel_wr: assert property (p_ch1_sel_wr) else $error("ch1 select write");

    property p_ch1_ofs_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_OFS_HI) |=> chan1_offset_o[23:8] == $past(wb_dat_i[15:0]);
    endproperty
    a_ch1_ofs_wr: assert property (p_ch1_ofs_wr) else $error("ch1 offset write");

    property p_ch1_ofs_lo;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_OFS_LO) |=> chan1_offset_lo_reg[7:0] == 8'h00
            && chan1_offset_o[7:0] == $past(wb_dat_i[15:8]);
    endproperty
    a_ch1_ofs_lo: assert property (p_ch1_ofs_lo) else $error("ch1 offset lo");

    property p_ch1_gain_hi_rst;
        @(posedge clk_i) $fell(rst_i) |-> chan1_gain_o == 24'h800000;
    endproperty
    a_ch1_gain_hi_rst: assert property (p_ch1_gain_hi_rst) else $error("ch1 gain reset");

    property p_ch1_gain_lo_rd;
        @(posedge clk_i) disable iff (rst_i)
            req && !wb_we_i && adr_ok && idx == ccr_pkg::CCR_IDX_CH1_GAIN_LO
            |=> wb_ack_o && wb_dat_o[7:0] == 8'h00;
    endproperty
    a_ch1_gain_lo_rd: assert property (p_ch1_gain_lo_rd) else $error("ch1 gain lo read");

    property p_coef_off;
        @(posedge clk_i) disable iff (rst_i)
            global_hpf_coeff_o == 4'h0 |-> !chan0_hpf_en_o && !chan1_hpf_en_o;
    endproperty
    a_coef_off: assert property (p_coef_off) else $error("filter not disabled");

    // One acknowledge, a cycle after each request
    property p_ack_next;
        @(posedge clk_i) disable iff (rst_i) req |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held");

    // Writes reach the datapath; filter enables follow setup bit 2 and the code
    property p_ch0_gain_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH0_GAIN_HI)
            |=> chan0_gain_o[23:8] == $past(wb_dat_i[15:0]);
    endproperty
    a_ch0_gain_wr: assert property (p_ch0_gain_wr) else $error("ch0 gain hi write");

    property p_ch0_gain_lo_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH0_GAIN_LO)
            |=> chan0_gain_o[7:0] == $past(wb_dat_i[15:8]);
    endproperty
    a_ch0_gain_lo_wr: assert property (p_ch0_gain_lo_wr) else $error("ch0 gain lo write");

    property p_ch1_gain_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_GAIN_HI)
            |=> chan1_gain_o[23:8] == $past(wb_dat_i[15:0]);
    endproperty
    a_ch1_gain_wr: assert property (p_ch1_gain_wr) else $error("ch1 gain hi write");

    property p_ch1_gain_lo_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH1_GAIN_LO)
            |=> chan1_gain_o[7:0] == $past(wb_dat_i[15:8]);
    endproperty
    a_ch1_gain_lo_wr: assert property (p_ch1_gain_lo_wr) else $error("ch1 gain lo write");

    property p_ch0_setup_wr;
        @(posedge clk_i) disable iff (rst_i)
            s_wr_full(ccr_pkg::CCR_IDX_CH0_SETUP)
            |=> chan0_phase_delay_o == $past(wb_dat_i[15:6])
            && chan0_input_select_o == $past(wb_dat_i[1:0]);
    endproperty
    a_ch0_setup_wr: assert property (p_ch0_setup_wr) else $error("ch0 setup write");

    property p_coef_wr;
        @(posedge clk_i) disable iff (rst_i)
            wr && adr_ok && idx == ccr_pkg::CCR_IDX_HPF_CTRL && wb_sel_i[0]
            |=> global_hpf_coeff_o == $past(wb_dat_i[3:0]);
    endproperty
    a_coef_wr: assert property (p_coef_wr) else $error("coeff write");

    property p_ch0_hpf;
        @(posedge clk_i) disable iff (rst_i) chan0_setup_reg[2] |-> !chan0_hpf_en_o;
    endproperty
    a_ch0_hpf: assert property (p_ch0_hpf) else $error("ch0 filter off");

    property p_ch1_hpf_on;
        @(posedge clk_i) disable iff (rst_i)
            global_hpf_coeff_o != 4'h0 && !chan1_setup_reg[2] |-> chan1_hpf_en_o;
    endproperty
    a_ch1_hpf_on: assert property (p_ch1_hpf_on) else $error("ch1 filter on");

endmodule

`default_nettype wire

// ### core/ccr_pkg.sv
// Constants for the per-channel calibration and setup register bank.
// Assumes a 32-bit classic Wishbone slave port; registers sit in the low 16 bits.
package ccr_pkg;

    // ****************************************************************
    // Register word indices
    // ****************************************************************
    localparam logic [5:0] CCR_IDX_CH0_SETUP    = 6'h09; // Channel 0 setup index
    localparam logic [5:0] CCR_IDX_CH0_GAIN_HI  = 6'h0c; // Channel 0 gain upper
    localparam logic [5:0] CCR_IDX_CH0_GAIN_LO  = 6'h0d; // Channel 0 gain lower
    localparam logic [5:0] CCR_IDX_CH1_SETUP    = 6'h0e; // Channel 1 setup
    localparam logic [5:0] CCR_IDX_CH1_OFS_HI   = 6'h0f; // Channel 1 offset upper
    localparam logic [5:0] CCR_IDX_CH1_OFS_LO   = 6'h10; // Channel 1 offset lower
    localparam logic [5:0] CCR_IDX_CH1_GAIN_HI  = 6'h11; // Channel 1 gain upper
    localparam logic [5:0] CCR_IDX_CH1_GAIN_LO  = 6'h12; // Channel 1 gain lower
    localparam logic [5:0] CCR_IDX_HPF_CTRL     = 6'h20; // Global filter control

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] CCR_RST_GAIN_HI = 16'h8000; // Unity gain
    localparam logic [15:0] CCR_RST_ZERO    = 16'h0000; // All other registers

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CCR_PHASE_MSB = 15; // Phase delay top bit
    localparam int CCR_PHASE_LSB = 6;  // Phase delay bottom bit
    localparam int CCR_HPF_OFF   = 2;  // Per-channel filter disable
    localparam int CCR_SEL_MSB   = 1;  // Input select top bit
    localparam int CCR_LOBYTE_MSB = 15; // Calibration low byte field
    localparam int CCR_LOBYTE_LSB = 8;
    localparam int CCR_COEF_MSB  = 3;  // Global coefficient field

    // Masks of writable bits
    localparam logic [15:0] CCR_MASK_SETUP = 16'hffc7; // Bits 5:3 reserved
    localparam logic [15:0] CCR_MASK_LO    = 16'hff00; // Low byte reserved
    localparam logic [15:0] CCR_MASK_COEF  = 16'h000f; // Four coefficient bits

    // ****************************************************************
    // Input select codes
    // ****************************************************************
    typedef enum logic [1:0] {
        CCR_SEL_PINS    = 2'h0, // Own differential pins
        CCR_SEL_SHORTED = 2'h1, // Inputs shorted
        CCR_SEL_POS_DC  = 2'h2, // Positive DC test signal
        CCR_SEL_NEG_DC  = 2'h3  // Negative DC test signal
    } ccr_sel_type;

    localparam logic [3:0] CCR_COEF_OFF = 4'h0; // Filter disabled

endpackage

// ### test/tb_top.sv
// Self-checking bench for the calibration and setup register bank.
// Assumes ccr_pkg and ccr_regs from core/ are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_i;                // 20 MHz bench clock
    logic        rst_i;                // Synchronous reset, high
    logic        wb_cyc_i;             // Bus cycle
    logic        wb_stb_i;             // Strobe
    logic        wb_we_i;              // Write enable
    logic [7:0]  wb_adr_i;             // Byte address
    logic [3:0]  wb_sel_i;             // Byte lanes
    logic [31:0] wb_dat_i;             // Write data
    logic [31:0] wb_dat_o;             // Read data
    logic        wb_ack_o;             // Acknowledge
    logic [23:0] chan0_gain_o;         // Channel 0 gain word
    logic [23:0] chan1_gain_o;         // Channel 1 gain word
    logic [23:0] chan1_offset_o;       // Channel 1 offset word
    logic [9:0]  chan0_phase_delay_o;  // Channel 0 phase
    logic [9:0]  chan1_phase_delay_o;  // Channel 1 phase
    logic        chan0_hpf_en_o;       // Channel 0 filter active
    logic        chan1_hpf_en_o;       // Channel 1 filter active
    logic [3:0]  global_hpf_coeff_o;   // Global coefficient code
    logic [1:0]  chan0_input_select_o; // Channel 0 input code
    logic [1:0]  chan1_input_select_o; // Channel 1 input code
    int          mismatches;           // Failed comparisons
    int          compares;             // All comparisons

    ccr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan0_gain_o(chan0_gain_o),
        .chan1_gain_o(chan1_gain_o), .chan1_offset_o(chan1_offset_o),
        .chan0_phase_delay_o(chan0_phase_delay_o), .chan1_phase_delay_o(chan1_phase_delay_o),
        .chan0_hpf_en_o(chan0_hpf_en_o), .chan1_hpf_en_o(chan1_hpf_en_o),
        .global_hpf_coeff_o(global_hpf_coeff_o), .chan0_input_select_o(chan0_input_select_o),
        .chan1_input_select_o(chan1_input_select_o));

    // ****************************************************************
    // Clock, counts and verdict
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // One exit point, also used when a bounded wait runs out
    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    // Classic cycle: hold everything until ack is sampled, then idle a cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [15:0] wdat, output logic [31:0] rdat);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {16'h0000, wdat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            // A hung bus ends the run rather than stalling it
            mismatches++;
            $display("Error ack expected 1 seen %b", wb_ack_o);
            finish_test();
        end
        @(posedge clk_i);
        @(negedge clk_i); // Let register outputs settle before checks
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [15:0] exp);
        logic [31:0] r;
        xfer(1'b0, adr, 4'hf, 16'h0000, r);
        chk(what, {16'h0000, exp}, r);
    endtask

    task automatic wr_rd(input string what, input logic [5:0] idx, input logic [15:0] d,
                         input logic [15:0] exp);
        logic [31:0] r;
        xfer(1'b1, {idx, 2'b00}, 4'hf, d, r);
        rd_chk(what, {idx, 2'b00}, exp);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk("ch0_gain_hi", {ccr_pkg::CCR_IDX_CH0_GAIN_HI, 2'b00}, 16'h8000);
        rd_chk("ch0_gain_lo", {ccr_pkg::CCR_IDX_CH0_GAIN_LO, 2'b00}, 16'h0000);
        rd_chk("ch1_setup", {ccr_pkg::CCR_IDX_CH1_SETUP, 2'b00}, 16'h0000);
        rd_chk("ch1_ofs_hi", {ccr_pkg::CCR_IDX_CH1_OFS_HI, 2'b00}, 16'h0000);
        rd_chk("ch1_ofs_lo", {ccr_pkg::CCR_IDX_CH1_OFS_LO, 2'b00}, 16'h0000);
        rd_chk("ch1_gain_hi", {ccr_pkg::CCR_IDX_CH1_GAIN_HI, 2'b00}, 16'h8000);
        rd_chk("ch1_gain_lo", {ccr_pkg::CCR_IDX_CH1_GAIN_LO, 2'b00}, 16'h0000);
        rd_chk("ch0_setup", {ccr_pkg::CCR_IDX_CH0_SETUP, 2'b00}, 16'h0000);
        chk("gain0_out", 32'h00800000, {8'h00, chan0_gain_o});
        chk("gain1_out", 32'h00800000, {8'h00, chan1_gain_o});
        chk("hpf1_out", 32'h0, {31'h0, chan1_hpf_en_o});
        $display("test reset_values done");
    endtask

    // Reserved low bytes drop all-ones writes; words join upper and high byte
    task automatic t_cal();
        wr_rd("ch0_gain_hi", ccr_pkg::CCR_IDX_CH0_GAIN_HI, 16'h1234, 16'h1234);
        wr_rd("ch0_gain_lo", ccr_pkg::CCR_IDX_CH0_GAIN_LO, 16'habff, 16'hab00);
        wr_rd("ch1_ofs_hi", ccr_pkg::CCR_IDX_CH1_OFS_HI, 16'h8765, 16'h8765);
        wr_rd("ch1_ofs_lo", ccr_pkg::CCR_IDX_CH1_OFS_LO, 16'h43ff, 16'h4300);
        wr_rd("ch1_gain_hi", ccr_pkg::CCR_IDX_CH1_GAIN_HI, 16'h0001, 16'h0001);
        wr_rd("ch1_gain_lo", ccr_pkg::CCR_IDX_CH1_GAIN_LO, 16'hffff, 16'hff00);
        chk("gain0_out", 32'h001234ab, {8'h00, chan0_gain_o});
        chk("ofs1_out", 32'h00876543, {8'h00, chan1_offset_o});
        chk("gain1_out", 32'h000001ff, {8'h00, chan1_gain_o});
        $display("test calibration done");
    endtask

    // Every input code on both channels, a negative phase, filter disable toggled
    task automatic t_setup();
        logic [15:0] d;
        logic [9:0]  ph;
        wr_rd("coeff", ccr_pkg::CCR_IDX_HPF_CTRL, 16'hfff5, 16'h0005);
        for (int c = 0; c < 4; c++) begin
            ph = 10'h200 + 10'(c);
            d = {ph, 3'b111, c[0], c[1:0]};
            wr_rd("ch1_setup", ccr_pkg::CCR_IDX_CH1_SETUP, d, d & 16'hffc7);
            wr_rd("ch0_setup", ccr_pkg::CCR_IDX_CH0_SETUP, d, d & 16'hffc7);
            chk("chan1_phase_delay", {22'h0, ph}, {22'h0, chan1_phase_delay_o});
            chk("sel1", 32'(c), {30'h0, chan1_input_select_o});
            chk("hpf1", {31'h0, ~c[0]}, {31'h0, chan1_hpf_en_o});
            chk("chan0_phase_delay", {22'h0, ph}, {22'h0, chan0_phase_delay_o});
            chk("sel0", 32'(c), {30'h0, chan0_input_select_o});
            chk("hpf0", {31'h0, ~c[0]}, {31'h0, chan0_hpf_en_o});
        end
        wr_rd("ch1_setup", ccr_pkg::CCR_IDX_CH1_SETUP, 16'h0000, 16'h0000);
        wr_rd("coeff", ccr_pkg::CCR_IDX_HPF_CTRL, 16'h0000, 16'h0000);
        chk("hpf1_off", 32'h0, {31'h0, chan1_hpf_en_o});
        wr_rd("coeff", ccr_pkg::CCR_IDX_HPF_CTRL, 16'h000f, 16'h000f);
        chk("hpf1_on", 32'h1, {31'h0, chan1_hpf_en_o});
        chk("coeff_out", 32'hf, {28'h0, global_hpf_coeff_o});
        $display("test setup_fields done");
    endtask

    // Byte lanes, an unmapped index and a misaligned address
    task automatic t_misc();
        logic [31:0] r;
        logic [7:0]  a;
        a = {ccr_pkg::CCR_IDX_CH1_OFS_HI, 2'b00};
        xfer(1'b1, a, 4'h1, 16'h00ff, r);
        rd_chk("ofs_hi_lane0", a, 16'h87ff);
        xfer(1'b1, a, 4'h2, 16'h5a00, r);
        rd_chk("ofs_hi_lane1", a, 16'h5aff);
        chk("ofs1_out", 32'h005aff43, {8'h00, chan1_offset_o});
        wr_rd("unmapped", 6'h02, 16'hffff, 16'h0000);
        a = {ccr_pkg::CCR_IDX_CH0_GAIN_HI, 2'b01};
        xfer(1'b1, a, 4'hf, 16'h0000, r);
        rd_chk("misaligned", a, 16'h0000);
        rd_chk("ch0_gain_hi", {ccr_pkg::CCR_IDX_CH0_GAIN_HI, 2'b00}, 16'h1234);
        $display("test lanes_unmapped done");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        mismatches = 0;
        compares   = 0;
        rst_i      = 1'b1;
        wb_cyc_i   = 1'b0;
        wb_stb_i   = 1'b0;
        wb_we_i    = 1'b0;
        wb_adr_i   = 8'h00;
        wb_sel_i   = 4'h0;
        wb_dat_i   = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_cal();
        t_setup();
        t_misc();
        finish_test();
    end
endmodule
`default_nettype wire
